// [adccp_device.sv]
// Converter end: serial configuration slave, sample clock path and output coding
`timescale 1ns/100ps
module adccp_device
  import adccp_pkg::*;
#(
  parameter int PER_W = 8
)(
  input wire logic core_clk,
  input wire logic rst_n,
  adccp_if.dev link,
  input wire logic signed [15:0] analog_diff,
  input wire logic clock_pin_true,
  input wire logic clock_pin_comp,
  input wire logic [1:0] ref_strap,
  output logic sample_clk,
  output logic [13:0] sample_code,
  output logic out_of_range_flag,
  output logic sample_valid,
  output logic duty_stabilizer_enable,
  output logic half_rate_clock_select,
  output logic single_clock_pin_select,
  output logic single_ended,
  output logic prog_ref_enable,
  output logic [1:0] ref_mode,
  output logic [2:0] ref_step_field,
  output logic [11:0] full_scale_mv,
  output logic irq
);
  typedef enum logic [2:0] {
    D_IDLE = 3'b001,
    D_INSTR = 3'b010,
    D_DATA = 3'b100
  } adccp_dstate_e;

  adccp_dstate_e state_reg, state_next;
  logic [7:0] clock_reg, clock_next, vref_reg, vref_next, format_reg, format_next;
  logic [7:0] status_reg, status_next, mask_reg, mask_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [14:0] shin_reg, shin_next;
  logic [2:0] bitpos_reg, bitpos_next;
  logic [7:0] tx_reg, tx_next;
  logic [12:0] addr_reg, addr_next;
  logic rw_reg, rw_next, o_reg, o_next, oe_reg, oe_next;
  logic sclk_s1, sclk_s2, sclk_s3, cs_s1, cs_s2, sdio_s1, sdio_s2;
  logic ptrue_s1, ptrue_s2, pcomp_s1, pcomp_s2;
  logic sel_prev_reg, div_reg, div_next, src_prev_reg, samp_reg, samp_next, samp_prev_reg;
  logic [PER_W-1:0] phase_reg, phase_next, period_reg, period_next;
  logic signed [15:0] held_reg, held_next;
  logic [13:0] code_reg, code_next;
  logic otr_reg, otr_next, valid_reg, valid_next, irq_reg, irq_next;
  logic [1:0] mode_reg, mode_next;
  logic [2:0] step_reg, step_next;
  logic [11:0] fs_reg, fs_next;
  logic sel, src, rise, fall, clr_status;
  logic [12:0] full_addr;
  logic [13:0] ob;

  // Register read mux
  function automatic logic [7:0] read_reg(input logic [12:0] a);
    case (a)
      REG_CLOCK: read_reg = clock_reg;
      REG_VREF: read_reg = vref_reg;
      REG_FORMAT: read_reg = format_reg;
      REG_SAMPLE_HI: read_reg = {2'h0, code_reg[13:8]};
      REG_SAMPLE_LO: read_reg = code_reg[7:0];
      REG_STATUS: read_reg = status_reg;
      REG_MASK: read_reg = mask_reg;
      default: read_reg = 8'h00;
    endcase
  endfunction

  // Pin synchronisers
  always_ff @(posedge core_clk) begin
    sclk_s1 <= link.sclk;
    sclk_s2 <= sclk_s1;
    sclk_s3 <= sclk_s2;
    cs_s1 <= link.cs_n;
    cs_s2 <= cs_s1;
    sdio_s1 <= link.sdio;
    sdio_s2 <= sdio_s1;
    ptrue_s1 <= clock_pin_true;
    ptrue_s2 <= ptrue_s1;
    pcomp_s1 <= clock_pin_comp;
    pcomp_s2 <= pcomp_s1;
  end

  // Serial slave, register file, clock path and coding
  always_comb begin
    state_next = state_reg;
    clock_next = clock_reg;
    vref_next = vref_reg;
    format_next = format_reg;
    mask_next = mask_reg;
    cnt_next = cnt_reg;
    shin_next = shin_reg;
    bitpos_next = bitpos_reg;
    tx_next = tx_reg;
    addr_next = addr_reg;
    rw_next = rw_reg;
    o_next = o_reg;
    oe_next = oe_reg;
    clr_status = 1'b0;
    full_addr = {shin_reg[11:0], sdio_s2};
    rise = sclk_s2 & ~sclk_s3;
    fall = ~sclk_s2 & sclk_s3;
    if (cs_s2) begin
      state_next = D_IDLE;
      oe_next = 1'b0;
    end else begin
      case (state_reg)
        D_IDLE: begin
          state_next = D_INSTR;
          cnt_next = 4'h0;
        end
        D_INSTR: begin
          if (rise) begin
            shin_next = {shin_reg[13:0], sdio_s2};
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == INSTR_LAST_BIT) begin
              rw_next = shin_reg[14];
              addr_next = full_addr;
              bitpos_next = 3'h0;
              state_next = D_DATA;
              if (shin_reg[14]) begin
                tx_next = read_reg(full_addr);
                clr_status = (full_addr == REG_STATUS);
              end
            end
          end
        end
        D_DATA: begin
          if (rise) begin
            shin_next = {shin_reg[13:0], sdio_s2};
            bitpos_next = bitpos_reg + 3'h1;
            if (bitpos_reg == BYTE_LAST_BIT) begin
              addr_next = addr_reg + 13'h0001;
              if (rw_reg) begin
                tx_next = read_reg(addr_reg + 13'h0001);
                clr_status = (addr_reg + 13'h0001 == REG_STATUS);
              end else begin
                case (addr_reg)
                  REG_CLOCK: clock_next = {3'h0, shin_reg[3:2], 1'b0, shin_reg[0], sdio_s2};
                  REG_VREF: vref_next = {4'h0, shin_reg[2:0], sdio_s2};
                  REG_FORMAT: format_next = {7'h00, sdio_s2};
                  REG_MASK: mask_next = {6'h00, shin_reg[0], sdio_s2};
                  default: clock_next = clock_reg;
                endcase
              end
            end
          end
          // Drive read data on falling edge
          if (fall && rw_reg) begin
            oe_next = 1'b1;
            o_next = tx_reg[7];
            tx_next = {tx_reg[6:0], 1'b0};
          end
        end
        default: state_next = D_IDLE;
      endcase
    end
    sel = clock_reg[CLK_SE_BIT] ? (clock_reg[CLK_PIN_SEL_BIT] ? ptrue_s2 : pcomp_s2) : ptrue_s2;
    div_next = (sel & ~sel_prev_reg) ? ~div_reg : div_reg;
    src = clock_reg[CLK_DIV2_BIT] ? div_reg : sel_prev_reg;
    phase_next = (phase_reg == {PER_W{1'b1}}) ? phase_reg : phase_reg + 1'b1;
    period_next = period_reg;
    if (src & ~src_prev_reg) begin
      period_next = phase_reg + 1'b1;
      phase_next = '0;
    end
    samp_next = clock_reg[CLK_DCS_BIT] ? (phase_reg < (period_reg >> 1)) : src;
    // Track while high, convert after fall
    held_next = samp_reg ? analog_diff : held_reg;
    valid_next = samp_prev_reg & ~samp_reg;
    code_next = code_reg;
    otr_next = otr_reg;
    if (held_reg < IN_MIN) begin
      ob = CODE_ZERO;
    end else if (held_reg > IN_MAX) begin
      ob = CODE_ONES;
    end else begin
      ob = held_reg[13:0] ^ CODE_MSB;
    end
    if (valid_next) begin
      otr_next = (held_reg < IN_MIN) || (held_reg > IN_MAX);
      code_next = format_reg[FMT_TWOS_BIT] ? (ob ^ CODE_MSB) : ob;
    end
    // Sticky status, cleared by a read, set wins
    status_next = clr_status ? 8'h00 : status_reg;
    if (valid_next) begin
      status_next[ST_SAMPLE_BIT] = 1'b1;
      status_next[ST_OTR_BIT] = status_next[ST_OTR_BIT] | otr_next;
    end
    irq_next = |(status_next & mask_next);
    mode_next = vref_reg[VREF_EN_BIT] ? REF_PROG : ref_strap;
    // Step field, unused code keeps last
    step_next = (vref_reg[2:0] == REF_STEP_UNUSED) ? step_reg : vref_reg[2:0];
    if (!vref_reg[VREF_EN_BIT]) begin
      step_next = 3'h0;
    end
    case (mode_next)
      REF_PROG: fs_next = FS_MV[step_next];
      REF_FIXED_1V: fs_next = FS_MV[6];
      REF_EXTERNAL: fs_next = FS_MV_EXTERNAL;
      default: fs_next = FS_MV[0];
    endcase
  end

  // State registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= D_IDLE;
      clock_reg <= CLOCK_RST;
      vref_reg <= VREF_RST;
      format_reg <= FORMAT_RST;
      status_reg <= STATUS_RST;
      mask_reg <= MASK_RST;
      cnt_reg <= 4'h0;
      shin_reg <= 15'h0000;
      bitpos_reg <= 3'h0;
      tx_reg <= 8'h00;
      addr_reg <= 13'h0000;
      rw_reg <= 1'b0;
      o_reg <= 1'b0;
      oe_reg <= 1'b0;
      sel_prev_reg <= 1'b0;
      div_reg <= 1'b0;
      src_prev_reg <= 1'b0;
      samp_reg <= 1'b0;
      samp_prev_reg <= 1'b0;
      phase_reg <= '0;
      period_reg <= '0;
      held_reg <= 16'sh0000;
      code_reg <= 14'h0000;
      otr_reg <= 1'b0;
      valid_reg <= 1'b0;
      irq_reg <= 1'b0;
      mode_reg <= REF_FIXED_2V;
      step_reg <= 3'h0;
      fs_reg <= 12'h000;
    end else begin
      state_reg <= state_next;
      clock_reg <= clock_next;
      vref_reg <= vref_next;
      format_reg <= format_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      cnt_reg <= cnt_next;
      shin_reg <= shin_next;
      bitpos_reg <= bitpos_next;
      tx_reg <= tx_next;
      addr_reg <= addr_next;
      rw_reg <= rw_next;
      o_reg <= o_next;
      oe_reg <= oe_next;
      sel_prev_reg <= sel;
      div_reg <= div_next;
      src_prev_reg <= src;
      samp_reg <= samp_next;
      samp_prev_reg <= samp_reg;
      phase_reg <= phase_next;
      period_reg <= period_next;
      held_reg <= held_next;
      code_reg <= code_next;
      otr_reg <= otr_next;
      valid_reg <= valid_next;
      irq_reg <= irq_next;
      mode_reg <= mode_next;
      step_reg <= step_next;
      fs_reg <= fs_next;
    end
  end

  assign link.dev_sdio_o = o_reg;
  assign link.dev_sdio_oe = oe_reg;
  assign sample_clk = samp_reg;
  assign sample_code = code_reg;
  assign out_of_range_flag = otr_reg;
  assign sample_valid = valid_reg;
  assign duty_stabilizer_enable = clock_reg[CLK_DCS_BIT];
  assign half_rate_clock_select = clock_reg[CLK_DIV2_BIT];
  assign single_clock_pin_select = clock_reg[CLK_PIN_SEL_BIT];
  assign single_ended = clock_reg[CLK_SE_BIT];
  assign prog_ref_enable = vref_reg[VREF_EN_BIT];
  assign ref_mode = mode_reg;
  assign ref_step_field = step_reg;
  assign full_scale_mv = fs_reg;
  assign irq = irq_reg;
endmodule

// [adccp_pkg.sv]
// Shared constants for the converter configuration port and its host controller
package adccp_pkg;
  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int SCLK_HALF_NS = 32;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SCLK_HALF_LAST = 4'(SCLK_HALF_CYC - 1);
  // Frame layout
  localparam logic [3:0] INSTR_LAST_BIT = 4'hF;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
  localparam logic [5:0] INSTR_BITS = 6'h10;
  localparam logic [1:0] LEN_FOUR_PLUS = 2'h3;
  localparam logic [5:0] LEN_FOUR_BITS = 6'h20;
  // Device register addresses
  localparam logic [12:0] REG_CLOCK = 13'h0006;
  localparam logic [12:0] REG_VREF = 13'h0008;
  localparam logic [12:0] REG_FORMAT = 13'h0010;
  localparam logic [12:0] REG_SAMPLE_HI = 13'h0011;
  localparam logic [12:0] REG_SAMPLE_LO = 13'h0012;
  localparam logic [12:0] REG_STATUS = 13'h0020;
  localparam logic [12:0] REG_MASK = 13'h0021;
  // Device field positions
  localparam int CLK_PIN_SEL_BIT = 4;
  localparam int CLK_SE_BIT = 3;
  localparam int CLK_DIV2_BIT = 1;
  localparam int CLK_DCS_BIT = 0;
  localparam int VREF_EN_BIT = 3;
  localparam int FMT_TWOS_BIT = 0;
  localparam int ST_OTR_BIT = 0;
  localparam int ST_SAMPLE_BIT = 1;
  // Device reset values
  localparam logic [7:0] CLOCK_RST = 8'h00;
  localparam logic [7:0] VREF_RST = 8'h00;
  localparam logic [7:0] FORMAT_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  // Reference modes (strap encoding uses the first three)
  localparam logic [1:0] REF_FIXED_2V = 2'h0;
  localparam logic [1:0] REF_FIXED_1V = 2'h1;
  localparam logic [1:0] REF_EXTERNAL = 2'h2;
  localparam logic [1:0] REF_PROG = 2'h3;
  localparam logic [2:0] REF_STEP_UNUSED = 3'h7;
  // Full scale in millivolts per reference step 000..110
  localparam logic [11:0] FS_MV [0:6] = '{12'h7D0, 12'h6F4, 12'h636, 12'h58C,
                                          12'h4EC, 12'h460, 12'h3E8};
  localparam logic [11:0] FS_MV_EXTERNAL = 12'h000;
  // Output coding
  localparam logic [13:0] CODE_MSB = 14'h2000;
  localparam logic [13:0] CODE_ZERO = 14'h0000;
  localparam logic [13:0] CODE_ONES = 14'h3FFF;
  localparam logic signed [15:0] IN_MIN = 16'shE000;
  localparam logic signed [15:0] IN_MAX = 16'sh1FFF;
  // Host register offsets and fields
  localparam logic [3:0] HREG_CMD = 4'h0;
  localparam logic [3:0] HREG_TX = 4'h1;
  localparam logic [3:0] HREG_RX = 4'h2;
  localparam logic [3:0] HREG_STATUS = 4'h3;
  localparam logic [3:0] HREG_MASK = 4'h4;
  localparam int HST_BUSY_BIT = 0;
  localparam int HST_DONE_BIT = 1;
endpackage

// [adccp_if.sv]
// Three-wire serial control link between host and converter
`timescale 1ns/100ps
interface adccp_if;
  logic sclk;
  logic cs_n;
  logic host_sdio_o;
  logic host_sdio_oe;
  logic dev_sdio_o;
  logic dev_sdio_oe;
  logic sdio;
  // Shared data wire, pulled high when nobody drives
  assign sdio = host_sdio_oe ? host_sdio_o : (dev_sdio_oe ? dev_sdio_o : 1'b1);
  modport host (output sclk, output cs_n, output host_sdio_o, output host_sdio_oe, input sdio);
  modport dev (input sclk, input cs_n, input sdio, output dev_sdio_o, output dev_sdio_oe);
endinterface

// [adccp_host.sv]
// Host controller driving the three-wire configuration link
`timescale 1ns/100ps
module adccp_host
  import adccp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  adccp_if.host link,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq
);
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_LEAD = 4'b0010,
    H_SHIFT = 4'b0100,
    H_TAIL = 4'b1000
  } adccp_hstate_e;

  adccp_hstate_e state_reg, state_next;
  logic [3:0] ph_reg, ph_next;
  logic [5:0] bit_reg, bit_next, nbits_reg, nbits_next;
  logic [47:0] sh_reg, sh_next;
  logic [31:0] tx_reg, tx_next, rx_reg, rx_next, rdata_reg, rdata_next;
  logic rw_reg, rw_next, done_reg, done_next, mask_reg, mask_next;
  logic sclk_reg, sclk_next, cs_n_reg, cs_n_next;
  logic sdo_reg, sdo_next, oe_reg, oe_next, irq_reg, irq_next;
  logic sdio_s1, sdio_s2;
  logic done_set;

  // Data line synchroniser
  always_ff @(posedge core_clk) begin
    sdio_s1 <= link.sdio;
    sdio_s2 <= sdio_s1;
  end

  // Command decode, serial sequencing and register reads
  always_comb begin
    state_next = state_reg;
    ph_next = ph_reg;
    bit_next = bit_reg;
    nbits_next = nbits_reg;
    sh_next = sh_reg;
    tx_next = tx_reg;
    rx_next = rx_reg;
    rw_next = rw_reg;
    mask_next = mask_reg;
    sclk_next = sclk_reg;
    cs_n_next = cs_n_reg;
    sdo_next = sdo_reg;
    oe_next = oe_reg;
    rdata_next = rdata_reg;
    done_set = 1'b0;
    case (state_reg)
      H_IDLE: begin
        if (reg_wr && reg_addr == HREG_TX) begin
          tx_next = reg_wdata;
        end
        if (reg_wr && reg_addr == HREG_CMD) begin
          sh_next = {reg_wdata[15:0], tx_reg};
          rw_next = reg_wdata[15];
          nbits_next = (reg_wdata[14:13] == LEN_FOUR_PLUS) ? INSTR_BITS + LEN_FOUR_BITS :
                       INSTR_BITS + {reg_wdata[14:13], 3'h0} + 6'h08;
          bit_next = 6'h00;
          ph_next = 4'h0;
          cs_n_next = 1'b0;
          sdo_next = reg_wdata[15];
          oe_next = 1'b1;
          state_next = H_LEAD;
        end
      end
      H_LEAD: begin
        ph_next = ph_reg + 4'h1;
        if (ph_reg == SCLK_HALF_LAST) begin
          ph_next = 4'h0;
          sclk_next = 1'b1;
          state_next = H_SHIFT;
        end
      end
      H_SHIFT: begin
        ph_next = ph_reg + 4'h1;
        if (ph_reg == SCLK_HALF_LAST) begin
          ph_next = 4'h0;
          if (sclk_reg) begin
            sclk_next = 1'b0;
            bit_next = bit_reg + 6'h01;
            if (bit_reg == nbits_reg - 6'h01) begin
              oe_next = 1'b0;
              state_next = H_TAIL;
            end else begin
              sh_next = {sh_reg[46:0], 1'b0};
              sdo_next = sh_reg[46];
              oe_next = !(rw_reg && (bit_reg + 6'h01) >= INSTR_BITS);
            end
          end else begin
            sclk_next = 1'b1;
            if (rw_reg && bit_reg >= INSTR_BITS) begin
              rx_next = {rx_reg[30:0], sdio_s2};
            end
          end
        end
      end
      H_TAIL: begin
        ph_next = ph_reg + 4'h1;
        if (ph_reg == SCLK_HALF_LAST) begin
          ph_next = 4'h0;
          if (!cs_n_reg) begin
            cs_n_next = 1'b1;
          end else begin
            done_set = 1'b1;
            state_next = H_IDLE;
          end
        end
      end
      default: begin
        state_next = H_IDLE;
        cs_n_next = 1'b1;
        sclk_next = 1'b0;
        oe_next = 1'b0;
      end
    endcase
    if (reg_wr && reg_addr == HREG_MASK) begin
      mask_next = reg_wdata[HST_DONE_BIT];
    end
    // Sticky done flag; a new completion wins over the read clear
    done_next = done_reg;
    if (reg_rd && reg_addr == HREG_STATUS) begin
      done_next = 1'b0;
    end
    if (done_set) begin
      done_next = 1'b1;
    end
    // Read data valid the cycle after the strobe
    rdata_next = 32'h00000000;
    if (reg_rd) begin
      case (reg_addr)
        HREG_TX: rdata_next = tx_reg;
        HREG_RX: rdata_next = rx_reg;
        HREG_STATUS: rdata_next = {30'h0, done_reg, state_reg != H_IDLE};
        HREG_MASK: rdata_next = {30'h0, mask_reg, 1'b0};
        default: rdata_next = 32'h00000000;
      endcase
    end
    irq_next = done_next & mask_next;
  end

  // State registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg <= H_IDLE;
      ph_reg <= 4'h0;
      bit_reg <= 6'h00;
      nbits_reg <= 6'h00;
      sh_reg <= 48'h000000000000;
      tx_reg <= 32'h00000000;
      rx_reg <= 32'h00000000;
      rw_reg <= 1'b0;
      done_reg <= 1'b0;
      mask_reg <= 1'b0;
      sclk_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      sdo_reg <= 1'b0;
      oe_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      irq_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ph_reg <= ph_next;
      bit_reg <= bit_next;
      nbits_reg <= nbits_next;
      sh_reg <= sh_next;
      tx_reg <= tx_next;
      rx_reg <= rx_next;
      rw_reg <= rw_next;
      done_reg <= done_next;
      mask_reg <= mask_next;
      sclk_reg <= sclk_next;
      cs_n_reg <= cs_n_next;
      sdo_reg <= sdo_next;
      oe_reg <= oe_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
    end
  end

  assign link.sclk = sclk_reg;
  assign link.cs_n = cs_n_reg;
  assign link.host_sdio_o = sdo_reg;
  assign link.host_sdio_oe = oe_reg;
  assign reg_rdata = rdata_reg;
  assign irq = irq_reg;
endmodule

// [adccp_asserts.sv]
// Link protocol checks between host controller and converter port
`timescale 1ns/100ps
module adccp_asserts (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic host_sdio_o,
  input wire logic host_sdio_oe,
  input wire logic dev_sdio_oe
);
  logic sclk_reg;
  logic [5:0] rise_reg;
  logic [5:0] rise_next;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Counts rising serial clock edges inside the current frame
  always_comb begin
    rise_next = cs_n ? 6'h00 : rise_reg + {5'h00, sclk & ~sclk_reg};
  end
  always_ff @(posedge core_clk) begin
    sclk_reg <= sclk;
    rise_reg <= rise_next;
  end
  a_single_driver: assert property (!(host_sdio_oe && dev_sdio_oe))
    else $error("both ends drive the data wire");
  a_idle_clock_low: assert property (cs_n |-> !sclk)
    else $error("serial clock high outside a frame");
  a_lead_time: assert property ($fell(cs_n) |-> !sclk [*8] ##1 sclk)
    else $error("first serial clock rise misplaced");
  a_half_period: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
    else $error("serial clock high time wrong");
  a_data_steady: assert property (sclk && host_sdio_oe |-> $stable(host_sdio_o))
    else $error("host data moved while clock high");
  a_frame_bits: assert property ($rose(cs_n) |-> rise_reg >= 6'h18 && rise_reg[2:0] == 3'h0)
    else $error("frame is not instruction plus whole bytes");
  a_tail_time: assert property ($rose(cs_n) |-> $past(sclk, 9) && !$past(sclk, 8))
    else $error("select rose at wrong time after last fall");
  a_dev_release: assert property (cs_n && $past(cs_n, 5) |-> !dev_sdio_oe)
    else $error("converter drives wire outside a frame");
  a_dev_turn: assert property ($rose(dev_sdio_oe) |-> !cs_n && !host_sdio_oe)
    else $error("converter took the wire at a bad moment");
  c_write_frame: cover property ($rose(cs_n) && rise_reg == 6'h18);
  c_read_frame: cover property ($rose(dev_sdio_oe));
  c_long_frame: cover property ($rose(cs_n) && rise_reg == 6'h28);
endmodule

// [tb_top.sv]
// Testbench joining host controller and converter port over the link
`timescale 1ns/100ps
module tb_top import adccp_pkg::*; ;
  logic core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, clock_pin_true = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [1:0] ref_strap = 2'h1, ref_mode;
  logic signed [15:0] analog_diff = 16'sh0000;
  logic host_irq, dev_irq, sample_clk, out_of_range_flag, sample_valid, single_ended;
  logic duty_stabilizer_enable, half_rate_clock_select, single_clock_pin_select, prog_ref_enable;
  logic [13:0] sample_code;
  logic [2:0] ref_step_field;
  logic [11:0] full_scale_mv;
  int n_errors = 0, compares = 0, cycles = 0;
  adccp_if adccp_if_i ();
  adccp_host adccp_host_i (.core_clk(core_clk), .rst_n(rst_n), .link(adccp_if_i.host),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(host_irq));
  adccp_device #(.PER_W(8)) adccp_device_i (.core_clk(core_clk), .rst_n(rst_n),
    .link(adccp_if_i.dev), .analog_diff(analog_diff), .clock_pin_true(clock_pin_true),
    .clock_pin_comp(~clock_pin_true), .ref_strap(ref_strap), .sample_clk(sample_clk),
    .sample_code(sample_code), .out_of_range_flag(out_of_range_flag),
    .sample_valid(sample_valid), .duty_stabilizer_enable(duty_stabilizer_enable),
    .half_rate_clock_select(half_rate_clock_select), .single_ended(single_ended),
    .single_clock_pin_select(single_clock_pin_select), .prog_ref_enable(prog_ref_enable),
    .ref_mode(ref_mode), .ref_step_field(ref_step_field), .full_scale_mv(full_scale_mv),
    .irq(dev_irq));
  adccp_asserts adccp_asserts_i (.core_clk(core_clk), .rst_n(rst_n), .sclk(adccp_if_i.sclk),
    .cs_n(adccp_if_i.cs_n), .host_sdio_o(adccp_if_i.host_sdio_o),
    .host_sdio_oe(adccp_if_i.host_sdio_oe), .dev_sdio_oe(adccp_if_i.dev_sdio_oe));
  // Core clock and converter input clock at one eighth of its rate
  always #2 core_clk = ~core_clk;
  always begin
    repeat (4) @(posedge core_clk);
    clock_pin_true <= ~clock_pin_true;
  end
  // Hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_errors++;
      print_verdict;
    end
  end
  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask
  // One framed access: load bytes, start, wait for completion interrupt
  task automatic xfer(input logic [15:0] cmd, input logic [31:0] tx, output logic [31:0] rx);
    int n;
    logic [31:0] s;
    wr(HREG_TX, tx);
    wr(HREG_CMD, {16'h0000, cmd});
    rd(HREG_STATUS, s);
    chk(s & 32'h1, 32'h1);
    n = 0;
    while (host_irq !== 1'b1 && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    rd(HREG_STATUS, s);
    chk(s, 32'h2);
    rd(HREG_RX, rx);
    chk(32'(host_irq), 32'h0);
  endtask
  // Apply an input level and compare a later sample
  task automatic smp(input logic signed [15:0] v, input logic [13:0] code, input logic flag);
    int n;
    analog_diff <= v;
    repeat (3) begin
      n = 0;
      @(posedge core_clk);
      while (sample_valid !== 1'b1 && n < 200) begin
        @(posedge core_clk);
        n++;
      end
    end
    chk({16'h0, sample_clk, out_of_range_flag, sample_code}, {17'h0, flag, code});
  endtask
  // Main sequence
  initial begin
    logic [31:0] rx;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk(32'({adccp_if_i.cs_n, adccp_if_i.sclk, full_scale_mv}), 32'h23E8);
    wr(HREG_MASK, 32'h2);
    xfer(16'h0006, 32'h1B00_0000, rx);
    chk(32'({duty_stabilizer_enable, half_rate_clock_select, single_clock_pin_select,
      single_ended}), 32'hF);
    xfer(16'h0006, 32'h0200_0000, rx);
    chk(32'({duty_stabilizer_enable, half_rate_clock_select, single_clock_pin_select,
      single_ended}), 32'h4);
    for (int i = 0; i < 7; i++) begin
      xfer(16'h0008, {5'h01, 3'(i), 24'h0}, rx);
      chk(32'({ref_mode, ref_step_field, full_scale_mv}), 32'({REF_PROG, 3'(i), FS_MV[i]}));
    end
    ref_strap <= 2'h0;
    xfer(16'h0008, 32'h0600_0000, rx);
    chk(32'({prog_ref_enable, ref_mode, full_scale_mv}), 32'h07D0);
    ref_strap <= 2'h2;
    repeat (4) @(posedge core_clk);
    chk(32'({ref_mode, full_scale_mv}), 32'h2000);
    xfer(16'hC006, 32'h0, rx);
    chk(rx & 32'h00FF_FFFF, 32'h0002_0006);
    xfer(16'h200F, 32'hA501_0000, rx);
    smp(16'sh0000, 14'h0000, 1'b0);
    smp(IN_MIN, 14'h2000, 1'b0);
    smp(16'sh2328, 14'h1FFF, 1'b1);
    xfer(16'h0010, 32'h0, rx);
    smp(16'sh0000, 14'h2000, 1'b0);
    smp(IN_MAX, 14'h3FFF, 1'b0);
    smp(16'shDCD8, 14'h0000, 1'b1);
    xfer(16'h0021, 32'h0100_0000, rx);
    chk(32'(dev_irq), 32'h1);
    xfer(16'h0006, 32'h0900_0000, rx);
    chk(32'({duty_stabilizer_enable, half_rate_clock_select, single_clock_pin_select,
      single_ended}), 32'h9);
    smp(16'sh0000, 14'h2000, 1'b0);
    xfer(16'hE010, 32'h0, rx);
    chk(rx, 32'h0020_0000);
    xfer(16'h8020, 32'h0, rx);
    chk(rx, 32'h2000_0003);
    chk(32'(dev_irq), 32'h0);
    print_verdict;
  end
endmodule
